// ===== logic/adc_serial_config_regs.sv
// ADC configuration register bank with three-wire serial write port and reset handling
// Summary of operation
// [RL1] Host resets every register to default after power-up before relying on them.
// [RL2] A high pulse on the reset pin returns all registers to defaults.
// [RL3] Writing one to bit 1 of 0x6C reinitialises all registers; bit reads zero.
// [RL4] Host keeps the reset pin low when using the software reset.
// [RL5] Host waits 25 ns after reset release before asserting select.
// [RL6] Host waits 5 ms after supplies rise before pulsing reset.
// [RL7] Host ties reset pin high when parallel pins configure the device.
// [RL8] Register 0x62 holds output data position and output clock position fields.
// [RL9] Register 0x6C holds the LVDS or CMOS output interface select field.
// [RL10] Register 0x6D holds power scaling and internal or external reference select.
// [RL11] Register 0x7E holds data termination, clock termination and LVDS drive current.
// [RL12] Bits shift only while select is low, sampled on serial clock falling edges.
// [RL13] Every 16th falling edge loads a word; trailing partial words are dropped.
// [RL14] Word carries eight address bits first, then eight data bits.
// [RL15] Host writes zero to every unused bit.
// [RL16] Writes to undefined addresses change no register.
// [RL17] A write updates all fields of its register at the completing edge.
module adc_serial_config_regs (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic reset_pin,
  input wire logic serial_select_n,
  input wire logic serial_clk,
  input wire logic serial_in_line,
  output logic [1:0] data_position,
  output logic [4:0] clkout_position,
  output logic global_standby,
  output logic low_speed_en,
  output logic output_number_format,
  output logic [2:0] test_pattern_sel,
  output logic [3:0] gain_code,
  output logic [13:0] user_pattern,
  output logic [7:0] input_clock_buffer_amp,
  output logic [1:0] output_interface_sel,
  output logic [2:0] power_scaling,
  output logic ext_vref_sel,
  output logic [2:0] data_termination,
  output logic [2:0] clkout_termination,
  output logic [1:0] lvds_current,
  output logic [1:0] drive_strength_x2,
  output logic word_loaded
);
  typedef struct packed {
    logic [15:0] shift;
    logic [3:0] count;
    logic [adc_cfg_pkg::NUM_REGS-1:0][7:0] regs;
    logic load;
  } bank_state_t;

  bank_state_t st_r;
  bank_state_t st_nxt;
  logic [2:0] pin_in;
  logic [2:0] pin_lvl;
  logic [2:0] pin_fell;
  logic [2:0] pin_init;
  logic hw_reset_lvl;
  logic select_active;
  logic sclk_fall;
  logic data_bit;
  logic [15:0] word;
  logic word_done;
  logic addr_hit;
  logic [3:0] addr_idx;
  logic soft_init;

  // Pin order: reset, select, serial clock; the data line has its own sync below
  assign pin_in = {serial_clk, serial_select_n, reset_pin};
  // Select and serial clock idle high, so no false edge or select follows reset
  assign pin_init = 3'b110;

  // Every asynchronous pin passes the same three-stage filter
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_sync
      pin_sync3 u_sync (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .async_in(pin_in[gi]),
        .init_level(pin_init[gi]),
        .level(pin_lvl[gi]),
        .fell(pin_fell[gi])
      );
    end
  endgenerate

  // Data line gets its own filter so its delay matches the clock path
  pin_sync3 u_data_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .async_in(serial_in_line),
    .init_level(1'b0),
    .level(data_bit),
    .fell()
  );

  assign hw_reset_lvl = pin_lvl[0];
  assign select_active = ~pin_lvl[1];
  assign sclk_fall = pin_fell[2];

  // Word as it stands once the current bit is appended, address byte first
  assign word = {st_r.shift[14:0], data_bit}; // [RL14]
  assign word_done = select_active && sclk_fall && (st_r.count == adc_cfg_pkg::LAST_BIT_COUNT);

  // Address decode against the defined register set
  always_comb
  begin
    addr_hit = 1'b0;
    addr_idx = 4'h0;
    for (int i = 0; i < adc_cfg_pkg::NUM_REGS; i++)
    begin
      if (word[15:8] == adc_cfg_pkg::REG_ADDR[i])
      begin
        addr_hit = 1'b1;
        addr_idx = 4'(i);
      end
    end
  end

  assign soft_init = addr_hit && (addr_idx == 4'(adc_cfg_pkg::IDX_IFSI)) &&
                     word[adc_cfg_pkg::SOFT_INIT_BIT];

  // Shift, count and register update; hardware reset level dominates everything
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.load = 1'b0;
    if (hw_reset_lvl)
    begin
      st_nxt.regs = adc_cfg_pkg::REG_RESET; // [RL2]
      st_nxt.count = 4'h0;
      st_nxt.shift = 16'h0000;
    end
    else if (!select_active)
    begin
      // A partial word is dropped when select goes high
      st_nxt.count = 4'h0; // [RL12] [RL13]
    end
    else if (sclk_fall)
    begin
      st_nxt.shift = word; // [RL12]
      st_nxt.count = st_r.count + 4'h1;
      if (word_done)
      begin
        st_nxt.load = 1'b1; // [RL13]
        if (soft_init)
          st_nxt.regs = adc_cfg_pkg::REG_RESET; // [RL3]
        else if (addr_hit)
          st_nxt.regs[addr_idx] = word[7:0]; // [RL17]
        // Unknown address: registers left untouched [RL16]
      end
    end
  end

  // Single state register; asynchronous reset loads defaults only
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_r.shift <= 16'h0000;
      st_r.count <= 4'h0;
      st_r.regs <= adc_cfg_pkg::REG_RESET;
      st_r.load <= 1'b0;
    end
    else
      st_r <= st_nxt;
  end

  // Field outputs are slices of the register flops
  assign data_position = st_r.regs[adc_cfg_pkg::IDX_EDGE][adc_cfg_pkg::DATA_POS_LSB +:
                         adc_cfg_pkg::DATA_POS_W]; // [RL8]
  assign clkout_position = st_r.regs[adc_cfg_pkg::IDX_EDGE][adc_cfg_pkg::CLKOUT_POS_LSB +:
                           adc_cfg_pkg::CLKOUT_POS_W]; // [RL8]
  assign global_standby = st_r.regs[adc_cfg_pkg::IDX_PSF][adc_cfg_pkg::STANDBY_BIT];
  assign low_speed_en = st_r.regs[adc_cfg_pkg::IDX_PSF][adc_cfg_pkg::LOW_SPEED_BIT];
  assign output_number_format = st_r.regs[adc_cfg_pkg::IDX_PSF][adc_cfg_pkg::NUM_FORMAT_BIT];
  assign test_pattern_sel = st_r.regs[adc_cfg_pkg::IDX_PAT][adc_cfg_pkg::PATTERN_LSB +:
                            adc_cfg_pkg::PATTERN_W];
  assign gain_code = st_r.regs[adc_cfg_pkg::IDX_GAIN][adc_cfg_pkg::GAIN_LSB +:
                     adc_cfg_pkg::GAIN_W];
  assign user_pattern = {st_r.regs[adc_cfg_pkg::IDX_UWH][adc_cfg_pkg::USER_HIGH_W-1:0],
                         st_r.regs[adc_cfg_pkg::IDX_UWL]};
  assign input_clock_buffer_amp = st_r.regs[adc_cfg_pkg::IDX_CBA];
  assign output_interface_sel = st_r.regs[adc_cfg_pkg::IDX_IFSI][adc_cfg_pkg::IFACE_SEL_LSB +:
                                adc_cfg_pkg::IFACE_SEL_W]; // [RL9]
  assign power_scaling = st_r.regs[adc_cfg_pkg::IDX_PTV][adc_cfg_pkg::SCALING_LSB +:
                         adc_cfg_pkg::SCALING_W]; // [RL10]
  assign ext_vref_sel = st_r.regs[adc_cfg_pkg::IDX_PTV][adc_cfg_pkg::VREF_SEL_BIT]; // [RL10]
  assign data_termination = st_r.regs[adc_cfg_pkg::IDX_TERM][adc_cfg_pkg::DATA_TERM_LSB +:
                            adc_cfg_pkg::DATA_TERM_W]; // [RL11]
  assign clkout_termination = st_r.regs[adc_cfg_pkg::IDX_TERM][adc_cfg_pkg::CLK_TERM_LSB +:
                              adc_cfg_pkg::CLK_TERM_W]; // [RL11]
  assign lvds_current = st_r.regs[adc_cfg_pkg::IDX_TERM][adc_cfg_pkg::LVDS_CURR_LSB +:
                        adc_cfg_pkg::LVDS_CURR_W]; // [RL11]
  assign drive_strength_x2 = st_r.regs[adc_cfg_pkg::IDX_BOOST][adc_cfg_pkg::DRIVE_X2_LSB +:
                             adc_cfg_pkg::DRIVE_X2_W];
  assign word_loaded = st_r.load;

  // Checks on the serial engine and register bank
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  sequence s_word_done;
    select_active && sclk_fall && (st_r.count == adc_cfg_pkg::LAST_BIT_COUNT) && !hw_reset_lvl;
  endsequence

  sequence s_soft_word;
    s_word_done ##0 soft_init;
  endsequence

  sequence s_plain_write;
    s_word_done ##0 (addr_hit && !soft_init);
  endsequence

  a_hw_reset_defaults: assert property ( // [RL2]
      hw_reset_lvl |=> st_r.regs == adc_cfg_pkg::REG_RESET)
    else $error("hardware reset did not restore defaults");

  a_soft_init_clears: assert property ( // [RL3]
      s_soft_word |=> word_loaded && st_r.regs == adc_cfg_pkg::REG_RESET)
    else $error("soft init did not restore defaults");

  a_soft_bit_low: assert property ( // [RL3]
      !st_r.regs[adc_cfg_pkg::IDX_IFSI][adc_cfg_pkg::SOFT_INIT_BIT])
    else $error("soft init bit stayed set");

  a_idle_no_shift: assert property ( // [RL12]
      !select_active |=> st_r.count == 4'h0 && !word_loaded)
    else $error("bits counted while select was high");

  a_shift_on_fall: assert property ( // [RL12]
      select_active && sclk_fall && !hw_reset_lvl |=>
      st_r.shift == {$past(st_r.shift[14:0]), $past(data_bit)})
    else $error("bit not shifted on falling edge");

  a_word_on_16th: assert property (s_word_done |=> word_loaded ##1 !word_loaded) // [RL13]
    else $error("sixteenth edge did not load exactly one word");

  a_load_only_16th: assert property ( // [RL13]
      word_loaded |-> $past(st_r.count) == adc_cfg_pkg::LAST_BIT_COUNT)
    else $error("word loaded before sixteen bits");

  a_write_lands: assert property ( // [RL14] [RL17]
      s_plain_write |=> st_r.regs[$past(addr_idx)] == st_r.shift[7:0])
    else $error("write data did not reach addressed register");

  a_unmapped_ignored: assert property ( // [RL16]
      s_word_done ##0 !addr_hit |=> $stable(st_r.regs))
    else $error("undefined address altered a register");

  a_iface_field: assert property ( // [RL9]
      s_plain_write ##0 (word[15:8] == adc_cfg_pkg::ADDR_INTERFACE_SOFT_INIT)
      |=> output_interface_sel == st_r.shift[4:3])
    else $error("interface select not updated");
endmodule

// ===== common/adc_cfg_pkg.sv
// Package: register map, field layout, reset values and timing of the ADC configuration bank
package adc_cfg_pkg;
  // Register addresses as sent in the address byte
  localparam logic [7:0] ADDR_OUTPUT_EDGE_POSITION = 8'h62;
  localparam logic [7:0] ADDR_POWER_SPEED_FORMAT = 8'h63;
  localparam logic [7:0] ADDR_PATTERN_CONTROL = 8'h65;
  localparam logic [7:0] ADDR_GAIN_SETTING = 8'h68;
  localparam logic [7:0] ADDR_USER_WORD_LOW = 8'h69;
  localparam logic [7:0] ADDR_USER_WORD_HIGH = 8'h6a;
  localparam logic [7:0] ADDR_CLOCK_BUFFER_AMP = 8'h6b;
  localparam logic [7:0] ADDR_INTERFACE_SOFT_INIT = 8'h6c;
  localparam logic [7:0] ADDR_POWER_TRIM_VBASIS = 8'h6d;
  localparam logic [7:0] ADDR_TERMINATION_DRIVE = 8'h7e;
  localparam logic [7:0] ADDR_DRIVE_BOOST = 8'h7f;
  localparam int NUM_REGS = 11;
  // Storage index of each register
  localparam int IDX_EDGE = 0;
  localparam int IDX_PSF = 1;
  localparam int IDX_PAT = 2;
  localparam int IDX_GAIN = 3;
  localparam int IDX_UWL = 4;
  localparam int IDX_UWH = 5;
  localparam int IDX_CBA = 6;
  localparam int IDX_IFSI = 7;
  localparam int IDX_PTV = 8;
  localparam int IDX_TERM = 9;
  localparam int IDX_BOOST = 10;
  localparam logic [NUM_REGS-1:0][7:0] REG_ADDR = {
    ADDR_DRIVE_BOOST, ADDR_TERMINATION_DRIVE, ADDR_POWER_TRIM_VBASIS,
    ADDR_INTERFACE_SOFT_INIT, ADDR_CLOCK_BUFFER_AMP, ADDR_USER_WORD_HIGH,
    ADDR_USER_WORD_LOW, ADDR_GAIN_SETTING, ADDR_PATTERN_CONTROL,
    ADDR_POWER_SPEED_FORMAT, ADDR_OUTPUT_EDGE_POSITION};
  // Default value of every register after either reset
  localparam logic [NUM_REGS-1:0][7:0] REG_RESET = '0;
  // Field positions (lsb and width)
  localparam int DATA_POS_LSB = 5;
  localparam int DATA_POS_W = 2;
  localparam int CLKOUT_POS_LSB = 0;
  localparam int CLKOUT_POS_W = 5;
  localparam int STANDBY_BIT = 7;
  localparam int LOW_SPEED_BIT = 4;
  localparam int NUM_FORMAT_BIT = 3;
  localparam int PATTERN_LSB = 5;
  localparam int PATTERN_W = 3;
  localparam int GAIN_LSB = 0;
  localparam int GAIN_W = 4;
  localparam int USER_HIGH_W = 6;
  localparam int IFACE_SEL_LSB = 3;
  localparam int IFACE_SEL_W = 2;
  localparam int SOFT_INIT_BIT = 1;
  localparam int SCALING_LSB = 5;
  localparam int SCALING_W = 3;
  localparam int VREF_SEL_BIT = 4;
  localparam int DATA_TERM_LSB = 5;
  localparam int DATA_TERM_W = 3;
  localparam int CLK_TERM_LSB = 2;
  localparam int CLK_TERM_W = 3;
  localparam int LVDS_CURR_LSB = 0;
  localparam int LVDS_CURR_W = 2;
  localparam int DRIVE_X2_LSB = 6;
  localparam int DRIVE_X2_W = 2;
  // Serial word layout
  localparam int WORD_BITS = 16;
  localparam logic [3:0] LAST_BIT_COUNT = 4'hf;
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_RESET_PULSE_NS = 10;
  localparam int RESET_PULSE_CYC_RAW = (T_RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_PULSE_CYC = (RESET_PULSE_CYC_RAW < 1) ? 1 : RESET_PULSE_CYC_RAW;
endpackage

// ===== logic/pin_sync3.sv
// Three-stage pin synchroniser with agreement filter and falling-edge pulse
module pin_sync3 (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic async_in,
  input wire logic init_level,
  output logic level,
  output logic fell
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    logic fell;
  } sync_state_t;

  sync_state_t st_r;
  sync_state_t st_nxt;

  // Stages hold the pin relative to its idle level, so an all-zero reset means idle
  // Stage one feeds stage two only; the filter looks at stages two and three
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.s1 = async_in ^ init_level;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.fell = 1'b0;
    if (st_r.s2 == st_r.s3)
    begin
      st_nxt.lvl = st_r.s3;
      // Edge is judged on the true pin level, not the stored one
      st_nxt.fell = (st_r.lvl ^ init_level) & ~(st_r.s3 ^ init_level);
    end
  end

  // Reset loads constants only; the stored zero stands for the idle level of the pin
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign level = st_r.lvl ^ init_level;
  assign fell = st_r.fell;
endmodule

// ===== dv/host_ctrl_model.sv
// Host controller model: drives the serial write link and the hardware reset pin
module host_ctrl_model (
  input wire logic clk_sys,
  output logic reset_pin,
  output logic serial_select_n,
  output logic serial_clk,
  output logic serial_in_line
);
  timeunit 1ns;
  timeprecision 1ns;

  // Serial-only mode: reset pin parked low, never tied high, as no parallel pin setup is used
  // Link clock parked high between frames
  initial
  begin
    reset_pin = 1'b0;
    serial_select_n = 1'b1;
    serial_clk = 1'b1;
    serial_in_line = 1'b0;
  end

  // Every change lands just after a falling system clock edge
  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // High pulse on the reset pin; the pin filter needs several cycles to see it
  task automatic hw_reset(input int width);
    idle(1);
    reset_pin = 1'b1;
    idle(width);
    reset_pin = 1'b0;
    idle(8);
  endtask

  // Shift n bits MSB first; stray clocks with select high come first and must be ignored
  task automatic shift(input logic [63:0] bits, input int n, input int stray);
    int i;
    idle(1);
    for (i = 0; i < 2 * stray; i++)
    begin
      serial_clk = ~serial_clk;
      serial_in_line = ~serial_in_line;
      idle(4);
    end
    serial_select_n = 1'b0;
    idle(4);
    for (i = n - 1; i >= 0; i--)
    begin
      serial_in_line = bits[i];
      idle(4);
      serial_clk = 1'b0;
      idle(4);
      serial_clk = 1'b1;
    end
    idle(4);
    serial_select_n = 1'b1;
    // Released data line shows the inverse so a stale level never looks valid
    serial_in_line = ~serial_in_line;
    idle(8);
  endtask
endmodule

// ===== dv/testbench.sv
// Self-checking bench for the serial configuration register bank
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  // Full 5 ms power-on wait (50000 cycles of 100 ns) ahead of the reset pulse
  localparam int POWER_ON_CYC = 50000;
  localparam logic [7:0] MASK [11] = '{8'h7f, 8'h98, 8'he0, 8'h0f, 8'hff, 8'h3f, 8'hff,
    8'h18, 8'hf0, 8'hff, 8'hc0};
  localparam logic [7:0] BAD [3] = '{8'h00, 8'h64, 8'hff};
  logic clk_sys, reset_n, reset_pin, serial_select_n, serial_clk, serial_in_line, word_loaded;
  logic [1:0] data_position, output_interface_sel, lvds_current, drive_strength_x2;
  logic [4:0] clkout_position;
  logic global_standby, low_speed_en, output_number_format, ext_vref_sel;
  logic [2:0] test_pattern_sel, power_scaling, data_termination, clkout_termination;
  logic [3:0] gain_code;
  logic [13:0] user_pattern;
  logic [7:0] input_clock_buffer_amp;
  logic [54:0] seen_v;
  logic [7:0] regs [11];
  logic [54:0] exp_q [$];
  logic [15:0] wq [$];
  int n_fail = 0;
  int checks_done = 0;

  adc_serial_config_regs adc_serial_config_regs_inst (.clk_sys, .reset_n, .reset_pin,
    .serial_select_n, .serial_clk, .serial_in_line, .data_position, .clkout_position,
    .global_standby, .low_speed_en, .output_number_format, .test_pattern_sel, .gain_code,
    .user_pattern, .input_clock_buffer_amp, .output_interface_sel, .power_scaling,
    .ext_vref_sel, .data_termination, .clkout_termination, .lvds_current,
    .drive_strength_x2, .word_loaded);
  host_ctrl_model host_ctrl_model_inst (.clk_sys, .reset_pin, .serial_select_n, .serial_clk,
    .serial_in_line);

  // All field outputs in one vector, same order as the expectation packer
  assign seen_v = {data_position, clkout_position, global_standby, low_speed_en,
    output_number_format, test_pattern_sel, gain_code, user_pattern, input_clock_buffer_amp,
    output_interface_sel, power_scaling, ext_vref_sel, data_termination, clkout_termination,
    lvds_current, drive_strength_x2};

  initial clk_sys = 1'b0;
  always #50 clk_sys = ~clk_sys;

  // Expected outputs from the register image
  function automatic logic [54:0] pack();
    return {regs[0][6:5], regs[0][4:0], regs[1][7], regs[1][4], regs[1][3], regs[2][7:5],
      regs[3][3:0], regs[5][5:0], regs[4], regs[6], regs[7][4:3], regs[8][7:5], regs[8][4],
      regs[9], regs[10][7:6]};
  endfunction

  // Register image update for one word; unknown addresses fall through untouched
  function automatic void apply(input logic [15:0] w);
    for (int i = 0; i < adc_cfg_pkg::NUM_REGS; i++)
      if (w[15:8] == adc_cfg_pkg::REG_ADDR[i])
        regs[i] = w[7:0];
    if (w[15:8] == adc_cfg_pkg::ADDR_INTERFACE_SOFT_INIT && w[1])
      regs = '{default: 8'h00};
  endfunction

  task automatic chk(input logic [54:0] seen, input logic [54:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Queued words go out in one select, plus extra random trailing bits
  task automatic send(input int extra, input int stray);
    logic [63:0] bits;
    bits = '0;
    foreach (wq[k])
    begin
      bits = {bits[47:0], wq[k]};
      apply(wq[k]);
      exp_q.push_back(pack());
    end
    bits = (bits << extra) | (64'($urandom()) & ((64'h1 << extra) - 64'h1));
    host_ctrl_model_inst.shift(bits, wq.size() * 16 + extra, stray);
    wq.delete();
  endtask

  // Each load pulse takes the oldest note; a pulse with none queued is itself a fault
  always @(negedge clk_sys)
    if (word_loaded === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk(seen_v, ~seen_v);
      else
        chk(seen_v, exp_q.pop_front());
    end

  task automatic conclude();
    if (n_fail == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Traffic needs about 0.6 ms after the power-on wait
  initial
  begin
    #9ms;
    n_fail++;
    conclude();
  end

  initial
  begin
    reset_n = 1'b0;
    regs = '{default: 8'h00};
    void'($urandom(32'h6941_2b8f));
    repeat (16) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (POWER_ON_CYC) @(negedge clk_sys);
    host_ctrl_model_inst.hw_reset(4);
    chk(seen_v, pack());
    // Every register with random legal fields, two words per select (one for the last), zero to two stray clocks before
    for (int r = 0; r < 3; r++)
      for (int i = 0; i < adc_cfg_pkg::NUM_REGS; i += 2)
      begin
        wq.push_back({adc_cfg_pkg::REG_ADDR[i], 8'($urandom()) & MASK[i]});
        if (i + 1 < adc_cfg_pkg::NUM_REGS)
          wq.push_back({adc_cfg_pkg::REG_ADDR[i + 1], 8'($urandom()) & MASK[i + 1]});
        send(0, r);
      end
    // Undefined addresses pulse the load but change nothing
    foreach (BAD[k])
      wq.push_back({BAD[k], 8'hff});
    send(0, 0);
    // Trailing partial word must be dropped
    wq.push_back({adc_cfg_pkg::ADDR_GAIN_SETTING, 8'h05});
    send(9, 0);
    chk(seen_v, pack());
    // Soft init mid-select clears everything, and the next word still lands
    wq.push_back({adc_cfg_pkg::ADDR_INTERFACE_SOFT_INIT, 8'h1a});
    wq.push_back({adc_cfg_pkg::ADDR_OUTPUT_EDGE_POSITION, 8'h55});
    wq.push_back({adc_cfg_pkg::ADDR_INTERFACE_SOFT_INIT, 8'h08});
    send(0, 0);
    // Hardware reset after configuration
    host_ctrl_model_inst.hw_reset(4);
    regs = '{default: 8'h00};
    chk(seen_v, pack());
    repeat (10) @(negedge clk_sys);
    chk(55'(exp_q.size()), 55'h0);
    conclude();
  end
endmodule
